//--- dv/ifs_fetch_model.sv
// Fetch-side model that offers queued bytes to the field splitter
`timescale 1ns/1ns
module ifs_fetch_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Byte stream
    output logic in_valid,
    output logic [7:0] in_byte,
    input wire logic in_ready,
    // Idle cycles after each taken byte
    input wire logic [3:0] gap
);
    logic [7:0] q[$];
    logic [7:0] last_byte = 8'h00;
    logic was_rst;
    int idle = 0;

    initial begin
        in_valid = 1'b0;
        in_byte = 8'hff;
    end

    always @(posedge core_clk) begin
        was_rst = rst;
        // Offer held until taken at an edge with ready high
        if (in_valid && in_ready) begin
            last_byte = q.pop_front();
            idle = gap;
        end
        #1;
        if (was_rst || idle > 0 || q.size() == 0) begin
            if (idle > 0) begin
                idle = idle - 1;
            end
            in_valid = 1'b0;
            // Idle line must not keep showing the byte just taken
            in_byte = ~last_byte;
        end else begin
            in_valid = 1'b1;
            in_byte = q[0];
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking bench for the instruction field splitter
`timescale 1ns/1ns
module tb;
    import ifs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic addr32_default = 1'b1;
    logic op32_default = 1'b1;
    logic [3:0] gap = 4'h0;
    logic in_valid, in_ready, out_valid, out_fault, out_seg_ovr_valid;
    logic out_addr_inv, out_op_inv, out_rep, out_repne, out_bus_hold;
    logic out_two_byte, out_modrm_valid, out_sib_valid;
    logic [7:0] in_byte;
    logic [15:0] out_fault_code, out_opcode;
    logic [3:0] out_len, out_prefix_count, out_disp_offset, out_imm_offset;
    logic [2:0] out_seg_ovr, out_reg, out_rm, wide_segment_selector;
    logic [2:0] out_index, out_base, out_disp_len, out_imm_len;
    logic [1:0] out_mod, narrow_segment_selector, out_scale;
    logic [31:0] out_disp, out_imm;
    ifs_reg_kind_type out_reg_kind;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    ifs_field_splitter u_dut (
        .core_clk, .rst, .in_valid, .in_byte, .in_ready, .addr32_default,
        .op32_default, .out_valid, .out_fault, .out_fault_code, .out_len,
        .out_prefix_count, .out_disp_offset, .out_imm_offset,
        .out_seg_ovr_valid, .out_seg_ovr, .out_addr_inv, .out_op_inv,
        .out_rep, .out_repne, .out_bus_hold, .out_opcode, .out_two_byte,
        .out_modrm_valid, .out_mod, .out_reg, .out_rm, .out_reg_kind,
        .narrow_segment_selector, .wide_segment_selector, .out_sib_valid,
        .out_scale, .out_index, .out_base, .out_disp, .out_disp_len,
        .out_imm, .out_imm_len
    );
    ifs_fetch_model u_fetch (
        .core_clk, .rst, .in_valid, .in_byte, .in_ready, .gap
    );

    always #25 core_clk = ~core_clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs under two hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            $display("MISMATCH run_time expected end seen hang");
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input logic [7:0] b[]);
        foreach (b[i]) u_fetch.q.push_back(b[i]);
    endtask

    // Returns inside the strobe cycle, while the fields still stand
    task automatic wait_result();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (out_valid !== 1'b1 && out_fault !== 1'b1 && n < 60);
        if (n >= 60) begin
            err_total++;
            $display("MISMATCH strobe expected 1 seen 0");
        end
    endtask

    task automatic expect_ok(input logic [3:0] len);
        wait_result();
        chk("out_valid", 1, out_valid);
        chk("in_ready", 0, in_ready);
        chk("out_len", len, out_len);
    endtask

    task automatic s_walk(input logic [3:0] g);
        gap = g;
        send('{8'h90, 8'h66, 8'h81, 8'hc0, 8'h34, 8'h12});
        expect_ok(4'h1);
        chk("opcode", 32'h0090, out_opcode);
        chk("modrm_valid", 0, out_modrm_valid);
        expect_ok(4'h5);
        chk("op_inv", 1, out_op_inv);
        chk("prefix_count", 1, out_prefix_count);
        chk("imm_offset", 3, out_imm_offset);
        chk("imm", 32'h1234, out_imm);
        chk("imm_len", 2, out_imm_len);
        chk("mod_reg_rm", 8'hc0, {out_mod, out_reg, out_rm});
        gap = 4'h0;
    endtask

    task automatic s_addr();
        addr32_default = 1'b1;
        send('{8'h8b, 8'h84, 8'h8d, 8'h78, 8'h56, 8'h34, 8'h12});
        expect_ok(4'h7);
        chk("scale_index", 5'h11, {out_scale, out_index});
        chk("base", 5, out_base);
        chk("disp", 32'h12345678, out_disp);
        chk("disp_len", 4, out_disp_len);
        chk("disp_offset", 3, out_disp_offset);
        // Mode 00 with low bits 101 means a bare 32-bit displacement
        send('{8'h8b, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01});
        expect_ok(4'h6);
        chk("sib_valid", 0, out_sib_valid);
        chk("disp", 32'h01020304, out_disp);
        @(posedge core_clk);
        #1;
        chk("ready_after", 1, in_ready);
        addr32_default = 1'b0;
        send('{8'h8b, 8'h86, 8'h34, 8'h12, 8'h8b, 8'h46, 8'h7f});
        expect_ok(4'h4);
        chk("disp", 32'h1234, out_disp);
        chk("disp_len", 2, out_disp_len);
        expect_ok(4'h3);
        chk("disp", 32'h7f, out_disp);
        chk("disp_len", 1, out_disp_len);
        addr32_default = 1'b1;
    endtask

    task automatic s_imm_seg();
        send('{8'hf6, 8'hc0, 8'h05, 8'hf7, 8'hc0, 8'h78, 8'h56, 8'h34});
        send('{8'h12, 8'h8e, 8'hd8, 8'h8c, 8'he0, 8'h1e, 8'h0f, 8'ha2});
        expect_ok(4'h3);
        chk("imm", 32'h05, out_imm);
        chk("imm_len", 1, out_imm_len);
        expect_ok(4'h6);
        chk("imm", 32'h12345678, out_imm);
        chk("imm_offset", 2, out_imm_offset);
        expect_ok(4'h2);
        chk("reg_kind", KIND_WIDE, out_reg_kind);
        chk("wide_seg", 3, wide_segment_selector);
        expect_ok(4'h2);
        chk("wide_seg", 4, wide_segment_selector);
        expect_ok(4'h1);
        chk("reg_kind", KIND_NARROW, out_reg_kind);
        chk("narrow_seg", 3, narrow_segment_selector);
        expect_ok(4'h2);
        chk("opcode", 32'h0fa2, out_opcode);
        chk("two_byte", 1, out_two_byte);
    endtask

    task automatic s_prefix();
        logic [7:0] pfx [11] = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64,
            8'h65, 8'h66, 8'h67, 8'hf0, 8'hf2, 8'hf3};
        // Flags as addr_inv, op_inv, rep, repne, bus_hold
        logic [4:0] flg [11] = '{0, 0, 0, 0, 0, 0, 8, 16, 1, 2, 4};
        for (int i = 0; i < 11; i++) begin
            send('{pfx[i], 8'h90});
            expect_ok(4'h2);
            chk("seg_ovr", (i < 6) ? {1'b1, i[2:0]} : 4'h0,
                {out_seg_ovr_valid, out_seg_ovr});
            chk("flags", flg[i], {out_addr_inv, out_op_inv, out_rep,
                out_repne, out_bus_hold});
        end
    endtask

    task automatic s_length();
        logic [7:0] b[];
        b = new[15];
        foreach (b[i]) b[i] = 8'h66;
        b[14] = 8'h90;
        send(b);
        expect_ok(4'hf);
        chk("prefix_count", 14, out_prefix_count);
        b = new[17];
        foreach (b[i]) b[i] = 8'h66;
        b[16] = 8'h90;
        send(b);
        wait_result();
        chk("out_fault", 1, out_fault);
        chk("out_valid", 0, out_valid);
        chk("fault_code", 0, out_fault_code);
        chk("fault_len", 15, out_len);
        chk("in_ready", 0, in_ready);
        expect_ok(4'h1);
        chk("op_inv", 0, out_op_inv);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        s_walk(4'h0);
        s_walk(4'h2);
        s_addr();
        s_imm_seg();
        s_prefix();
        s_length();
        tally_and_finish();
    end
endmodule

//--- hw/ifs_field_splitter.sv
// Splits a byte stream of x86 instructions into their fields
//
// Notes on behaviour
// [RULE_01] Instructions from one up to fifteen bytes long are accepted.
// [RULE_02] A sixteenth byte raises a protection fault with error code zero.
// [RULE_03] Mode byte top two and low three bits select the addressing form.
// [RULE_04] Mode byte middle bits: general, narrow or wide segment selector.
// [RULE_05] Scale/index/base byte: top bits scale, middle bits index.
// [RULE_06] Low three bits of scale/index/base byte pick the base register.
// [RULE_07] Any number of prefixes, then a one or two byte opcode.
// [RULE_08] Displacement and immediate trail, each 0, 8, 16 or 32 bits.
// [RULE_09] An instruction may start at any byte, no alignment needed.
// [RULE_10] Segment, address size, operand size, repeat, bus hold prefixes.
// [RULE_11] Total length and field offsets are reported per instruction.
`timescale 1ns/1ns
`include "ifs_map.svh"
module ifs_field_splitter #(
    parameter int MAX_LEN = `IFS_MAX_LEN
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Byte stream from fetch
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    output logic in_ready,
    // Default sizes of the code segment
    input wire logic addr32_default,
    input wire logic op32_default,
    // Result strobes
    output logic out_valid,
    output logic out_fault,
    output logic [15:0] out_fault_code,
    // Length and boundaries
    output logic [3:0] out_len,
    output logic [3:0] out_prefix_count,
    output logic [3:0] out_disp_offset,
    output logic [3:0] out_imm_offset,
    // Prefix effects
    output logic out_seg_ovr_valid,
    output logic [2:0] out_seg_ovr,
    output logic out_addr_inv,
    output logic out_op_inv,
    output logic out_rep,
    output logic out_repne,
    output logic out_bus_hold,
    // Opcode
    output logic [15:0] out_opcode,
    output logic out_two_byte,
    // Mode byte
    output logic out_modrm_valid,
    output logic [1:0] out_mod,
    output logic [2:0] out_reg,
    output logic [2:0] out_rm,
    output ifs_pkg::ifs_reg_kind_type out_reg_kind,
    output logic [1:0] narrow_segment_selector,
    output logic [2:0] wide_segment_selector,
    // Scale/index/base byte
    output logic out_sib_valid,
    output logic [1:0] out_scale,
    output logic [2:0] out_index,
    output logic [2:0] out_base,
    // Trailing fields, little endian
    output logic [31:0] out_disp,
    output logic [2:0] out_disp_len,
    output logic [31:0] out_imm,
    output logic [2:0] out_imm_len
);
    import ifs_pkg::*;

    ifs_state_type state, next_state;
    logic accept, is_prefix, op_modrm, sib_need, addr32, op32;
    logic [2:0] idx, next_disp_len, next_imm_len, mod_disp;
    ifs_imm_kind_type op_imm;

    function automatic logic [2:0] imm_bytes(ifs_imm_kind_type k,
                                             logic wide);
        case (k)
            IMM_BYTE: imm_bytes = 3'd1;
            IMM_WORD: imm_bytes = 3'd2;
            IMM_FULL: imm_bytes = wide ? 3'd4 : 3'd2;
            default: imm_bytes = 3'd0;
        endcase
    endfunction

    function automatic ifs_state_type tail(logic [2:0] dl, logic [2:0] il);
        if (dl != 3'd0) tail = ST_DISP;
        else if (il != 3'd0) tail = ST_IMM;
        else tail = ST_EMIT;
    endfunction

    // Stalled only while a result or a fault is shown
    assign in_ready = (state != ST_EMIT) && (state != ST_FAULT); // RULE_09
    assign accept = in_valid && in_ready;
    assign out_valid = (state == ST_EMIT);
    assign out_fault = (state == ST_FAULT);
    assign out_fault_code = `IFS_FAULT_CODE; // RULE_02
    assign narrow_segment_selector = out_reg[1:0]; // RULE_04
    assign wide_segment_selector = out_reg; // RULE_04
    assign addr32 = addr32_default ^ out_addr_inv; // RULE_10
    assign op32 = op32_default ^ out_op_inv; // RULE_10

    always_comb begin
        case (in_byte)
            `IFS_PFX_ES, `IFS_PFX_CS, `IFS_PFX_SS, `IFS_PFX_DS,
            `IFS_PFX_FS, `IFS_PFX_GS, `IFS_PFX_OPSZ, `IFS_PFX_ADSZ,
            `IFS_PFX_LOCK, `IFS_PFX_REPNE, `IFS_PFX_REP: is_prefix = 1'b1;
            default: is_prefix = 1'b0;
        endcase
    end

    // Opcode class table; only forms that shape the length are listed
    always_comb begin
        op_modrm = 1'b0;
        op_imm = IMM_NONE;
        if (state == ST_OPC2) begin
            case (in_byte) inside
                [8'h80:8'h8f]: op_imm = IMM_FULL;
                8'ha4, 8'hac, 8'hba: begin
                    op_modrm = 1'b1;
                    op_imm = IMM_BYTE;
                end
                [8'h00:8'h03], [8'h20:8'h23], [8'h40:8'h4f],
                [8'h90:8'h9f], 8'ha3, 8'ha5, 8'hab, 8'had, 8'haf,
                [8'hb0:8'hb7], [8'hbb:8'hc1]: op_modrm = 1'b1;
                default: op_modrm = 1'b0;
            endcase
        end else begin
            case (in_byte) inside
                [8'h00:8'h3f]: begin
                    op_modrm = (in_byte[2] == 1'b0);
                    if (in_byte[2:0] == 3'h4) op_imm = IMM_BYTE;
                    if (in_byte[2:0] == 3'h5) op_imm = IMM_FULL;
                end
                8'h69, 8'h81, 8'hc7: begin
                    op_modrm = 1'b1;
                    op_imm = IMM_FULL;
                end
                8'h6b, 8'h80, 8'h82, 8'h83, 8'hc0, 8'hc1, 8'hc6: begin
                    op_modrm = 1'b1;
                    op_imm = IMM_BYTE;
                end
                8'h62, 8'h63, [8'h84:8'h8f], [8'hc4:8'hc5],
                [8'hd0:8'hd3], [8'hd8:8'hdf], 8'hf6, 8'hf7, 8'hfe,
                8'hff: op_modrm = 1'b1;
                8'h6a, [8'h70:8'h7f], 8'ha8, [8'hb0:8'hb7], 8'hcd,
                [8'he0:8'he7], 8'heb: op_imm = IMM_BYTE;
                8'h68, 8'ha9, [8'hb8:8'hbf], 8'he8, 8'he9: op_imm = IMM_FULL;
                8'hc2, 8'hca: op_imm = IMM_WORD;
                default: op_imm = IMM_NONE;
            endcase
        end
    end

    // Displacement size implied by mode and low bits of the mode byte
    always_comb begin
        mod_disp = 3'd0;
        sib_need = 1'b0;
        if (in_byte[7:6] == `IFS_MOD_DISP8) mod_disp = 3'd1; // RULE_03
        else if (in_byte[7:6] == `IFS_MOD_DISPW)
            mod_disp = addr32 ? 3'd4 : 3'd2;
        else if (in_byte[7:6] == `IFS_MOD_NODISP) begin
            if (addr32 && in_byte[2:0] == `IFS_RM_D32) mod_disp = 3'd4;
            if (!addr32 && in_byte[2:0] == `IFS_RM_D16) mod_disp = 3'd2;
        end
        // Only 32-bit addressing carries the extra byte
        if (addr32 && in_byte[7:6] != `IFS_MOD_REG &&
            in_byte[2:0] == `IFS_RM_SIB) sib_need = 1'b1; // RULE_03
    end

    always_comb begin
        next_state = state;
        next_disp_len = out_disp_len;
        next_imm_len = out_imm_len;
        case (state)
            ST_FIRST, ST_OPC2: if (accept) begin
                if (state == ST_FIRST && is_prefix) begin
                    next_state = ST_FIRST; // RULE_07
                end else if (state == ST_FIRST && in_byte == `IFS_ESCAPE) begin
                    next_state = ST_OPC2; // RULE_07
                end else begin
                    next_imm_len = imm_bytes(op_imm, op32); // RULE_08
                    next_state = op_modrm ? ST_MODRM
                                          : tail(3'd0, next_imm_len);
                end
            end
            ST_MODRM: if (accept) begin
                // Test forms of the unary group carry an immediate
                if (!out_two_byte && in_byte[5:3] == 3'd0) begin
                    if (out_opcode[7:0] == `IFS_OP_GRP3B) next_imm_len = 3'd1;
                    if (out_opcode[7:0] == `IFS_OP_GRP3V)
                        next_imm_len = imm_bytes(IMM_FULL, op32);
                end
                next_disp_len = mod_disp; // RULE_08
                next_state = sib_need ? ST_SIB : tail(mod_disp, next_imm_len);
            end
            ST_SIB: if (accept) begin
                if (out_mod == `IFS_MOD_NODISP && in_byte[2:0] == `IFS_RM_D32)
                    next_disp_len = 3'd4; // RULE_06
                next_state = tail(next_disp_len, out_imm_len);
            end
            ST_DISP: if (accept && idx == out_disp_len - 3'd1)
                next_state = tail(3'd0, out_imm_len);
            ST_IMM: if (accept && idx == out_imm_len - 3'd1)
                next_state = ST_EMIT;
            default: next_state = ST_FIRST;
        endcase
        // Byte past the limit: drop the instruction
        if (accept && out_len == 4'(MAX_LEN)) next_state = ST_FAULT; // RULE_02
    end

    always_ff @(posedge core_clk) begin
        if (rst) state <= ST_FIRST;
        else state <= next_state;
    end

    // Length, field offsets and the byte index within a field
    always_ff @(posedge core_clk) begin
        if (rst || state == ST_EMIT || state == ST_FAULT) begin
            out_len <= 4'd0;
            out_prefix_count <= 4'd0;
            out_disp_offset <= 4'd0;
            out_imm_offset <= 4'd0;
            idx <= 3'd0;
        end else if (accept) begin
            // Held at the limit so the fault cycle still shows it
            if (next_state != ST_FAULT)
                out_len <= out_len + 4'd1; // RULE_01 RULE_11
            if (state == ST_FIRST && is_prefix)
                out_prefix_count <= out_prefix_count + 4'd1; // RULE_11
            idx <= (next_state != state) ? 3'd0 : idx + 3'd1;
            if (next_state == ST_DISP && state != ST_DISP)
                out_disp_offset <= out_len + 4'd1; // RULE_11
            if (next_state == ST_IMM && state != ST_IMM)
                out_imm_offset <= out_len + 4'd1; // RULE_11
        end
    end

    // Prefix effects apply to this instruction only
    always_ff @(posedge core_clk) begin
        if (rst || state == ST_EMIT || state == ST_FAULT) begin
            out_seg_ovr_valid <= 1'b0;
            out_seg_ovr <= 3'd0;
            out_addr_inv <= 1'b0;
            out_op_inv <= 1'b0;
            out_rep <= 1'b0;
            out_repne <= 1'b0;
            out_bus_hold <= 1'b0;
        end else if (accept && state == ST_FIRST && is_prefix) begin
            case (in_byte) // RULE_10
                `IFS_PFX_OPSZ: out_op_inv <= 1'b1;
                `IFS_PFX_ADSZ: out_addr_inv <= 1'b1;
                `IFS_PFX_LOCK: out_bus_hold <= 1'b1;
                `IFS_PFX_REPNE: out_repne <= 1'b1;
                `IFS_PFX_REP: out_rep <= 1'b1;
                `IFS_PFX_FS, `IFS_PFX_GS: begin
                    out_seg_ovr_valid <= 1'b1;
                    out_seg_ovr <= {2'b10, in_byte[0]};
                end
                default: begin
                    out_seg_ovr_valid <= 1'b1;
                    out_seg_ovr <= {1'b0, in_byte[4:3]};
                end
            endcase
        end
    end

    // Opcode, mode byte and scale/index/base byte
    always_ff @(posedge core_clk) begin
        if (rst || state == ST_EMIT || state == ST_FAULT) begin
            out_opcode <= 16'h0000;
            out_two_byte <= 1'b0;
            out_modrm_valid <= 1'b0;
            out_mod <= 2'd0;
            out_reg <= 3'd0;
            out_rm <= 3'd0;
            out_reg_kind <= KIND_GENERAL;
            out_sib_valid <= 1'b0;
            out_scale <= 2'd0;
            out_index <= 3'd0;
            out_base <= 3'd0;
        end else if (accept) begin
            if (state == ST_FIRST && !is_prefix) begin
                out_opcode <= {8'h00, in_byte}; // RULE_07
                out_two_byte <= (in_byte == `IFS_ESCAPE);
                if (in_byte == `IFS_OP_SEG_FROM || in_byte == `IFS_OP_SEG_TO)
                    out_reg_kind <= KIND_WIDE; // RULE_04
                // Push and pop of the four older segments
                if (in_byte[7:5] == 3'b000 && in_byte[2:1] == 2'b11 &&
                    in_byte != `IFS_ESCAPE) begin
                    out_reg_kind <= KIND_NARROW; // RULE_04
                    out_reg <= in_byte[5:3];
                end
            end
            if (state == ST_OPC2) out_opcode <= {out_opcode[7:0], in_byte};
            if (state == ST_MODRM) begin
                out_modrm_valid <= 1'b1;
                out_mod <= in_byte[`IFS_HI_MSB:`IFS_HI_LSB]; // RULE_03
                out_reg <= in_byte[`IFS_MID_MSB:`IFS_MID_LSB]; // RULE_04
                out_rm <= in_byte[`IFS_LO_MSB:`IFS_LO_LSB]; // RULE_03
            end
            if (state == ST_SIB) begin
                out_sib_valid <= 1'b1;
                out_scale <= in_byte[`IFS_HI_MSB:`IFS_HI_LSB]; // RULE_05
                out_index <= in_byte[`IFS_MID_MSB:`IFS_MID_LSB]; // RULE_05
                out_base <= in_byte[`IFS_LO_MSB:`IFS_LO_LSB]; // RULE_06
            end
        end
    end

    // Trailing fields
    always_ff @(posedge core_clk) begin
        if (rst || state == ST_EMIT || state == ST_FAULT) begin
            out_disp <= 32'h0000_0000;
            out_imm <= 32'h0000_0000;
            out_disp_len <= 3'd0;
            out_imm_len <= 3'd0;
        end else begin
            out_disp_len <= next_disp_len;
            out_imm_len <= next_imm_len;
            if (accept && state == ST_DISP)
                out_disp[{idx[1:0], 3'b000} +: 8] <= in_byte; // RULE_08
            if (accept && state == ST_IMM)
                out_imm[{idx[1:0], 3'b000} +: 8] <= in_byte; // RULE_08
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_len_range: assert property ( // RULE_01
        out_valid |-> out_len >= 4'd1)
        else $error("instruction emitted with zero length");
    chk_fault_raise: assert property ( // RULE_02
        accept && out_len == 4'd15 |=>
        out_fault && out_fault_code == 16'h0000 && out_len == 4'd15)
        else $error("sixteenth byte did not fault");
    chk_fault_pulse: assert property ( // RULE_02
        out_fault |=> !out_fault && in_ready && out_len == 4'd0)
        else $error("fault not a single pulse followed by restart");
    chk_mode_split: assert property ( // RULE_03
        state == ST_MODRM && accept |=>
        out_mod == $past(in_byte[7:6]) && out_rm == $past(in_byte[2:0]))
        else $error("mode or low field of mode byte wrong");
    chk_reg_select: assert property ( // RULE_04
        state == ST_MODRM && accept |=>
        wide_segment_selector == $past(in_byte[5:3]) &&
        narrow_segment_selector == $past(in_byte[4:3]))
        else $error("register selector of mode byte wrong");
    chk_sib_scale: assert property ( // RULE_05
        state == ST_SIB && accept |=>
        out_scale == $past(in_byte[7:6]) &&
        out_index == $past(in_byte[5:3]))
        else $error("scale or index wrong");
    chk_sib_base: assert property ( // RULE_06
        state == ST_SIB && accept |=>
        out_base == $past(in_byte[2:0]) && out_sib_valid)
        else $error("base register wrong");
    chk_opcode_bytes: assert property ( // RULE_07
        out_valid |-> out_len >=
        out_prefix_count + 4'd1 + {3'd0, out_two_byte})
        else $error("fewer bytes than prefixes plus opcode");
    chk_trail_sizes: assert property ( // RULE_08
        out_valid |->
        out_disp_len inside {3'd0, 3'd1, 3'd2, 3'd4} &&
        out_imm_len inside {3'd0, 3'd1, 3'd2, 3'd4})
        else $error("illegal trailing field size");
    chk_any_start: assert property ( // RULE_09
        out_valid |=> state == ST_FIRST && in_ready && out_len == 4'd0)
        else $error("next instruction start not accepted");
    chk_lock_flag: assert property ( // RULE_10
        state == ST_FIRST && accept &&
        in_byte == `IFS_PFX_LOCK |=> out_bus_hold)
        else $error("bus hold prefix not recorded");
    chk_len_sum: assert property ( // RULE_11
        out_valid |-> 5'(out_len) ==
        5'(out_prefix_count) + 5'd1 + 5'(out_two_byte) +
        5'(out_modrm_valid) + 5'(out_sib_valid) + 5'(out_disp_len) +
        5'(out_imm_len))
        else $error("length disagrees with fields");

    cov_two_byte: cover property (out_valid && out_two_byte &&
        out_prefix_count != 4'd0);
    cov_sib_disp: cover property (out_valid && out_sib_valid &&
        out_disp_len == 3'd4);
    cov_fault: cover property (out_fault);
    cov_imm_full: cover property (out_valid && out_imm_len == 3'd4);
endmodule

//--- hw/ifs_map.svh
// Constants for the instruction field splitter
`ifndef IFS_MAP_SVH
`define IFS_MAP_SVH

// Length limit and the error code sent with the fault
`define IFS_MAX_LEN 15
`define IFS_FAULT_CODE 16'h0000

// Escape to the two-byte opcode map
`define IFS_ESCAPE 8'h0f

// Prefix encodings
`define IFS_PFX_ES 8'h26
`define IFS_PFX_CS 8'h2e
`define IFS_PFX_SS 8'h36
`define IFS_PFX_DS 8'h3e
`define IFS_PFX_FS 8'h64
`define IFS_PFX_GS 8'h65
`define IFS_PFX_OPSZ 8'h66
`define IFS_PFX_ADSZ 8'h67
`define IFS_PFX_LOCK 8'hf0
`define IFS_PFX_REPNE 8'hf2
`define IFS_PFX_REP 8'hf3

// Field positions, shared by the mode byte and the scale/index/base byte
`define IFS_HI_MSB 7
`define IFS_HI_LSB 6
`define IFS_MID_MSB 5
`define IFS_MID_LSB 3
`define IFS_LO_MSB 2
`define IFS_LO_LSB 0

// Special mode and base codes
`define IFS_MOD_REG 2'h3
`define IFS_MOD_NODISP 2'h0
`define IFS_MOD_DISP8 2'h1
`define IFS_MOD_DISPW 2'h2
`define IFS_RM_SIB 3'h4
`define IFS_RM_D32 3'h5
`define IFS_RM_D16 3'h6

// Opcodes whose mode byte changes meaning
`define IFS_OP_SEG_FROM 8'h8c
`define IFS_OP_SEG_TO 8'h8e
`define IFS_OP_GRP3B 8'hf6
`define IFS_OP_GRP3V 8'hf7

`endif

//--- hw/ifs_pkg.sv
// Types for the instruction field splitter
package ifs_pkg;
    typedef enum logic [2:0] {
        ST_FIRST, ST_OPC2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM, ST_EMIT,
        ST_FAULT
    } ifs_state_type;
    typedef enum logic [1:0] {
        IMM_NONE, IMM_BYTE, IMM_WORD, IMM_FULL
    } ifs_imm_kind_type;
    typedef enum logic [1:0] {
        KIND_GENERAL, KIND_NARROW, KIND_WIDE
    } ifs_reg_kind_type;
endpackage
